// ===== include/sp_pkg.sv
// package: constants and types of the serial port configuration block
package sp_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [14:0] REG_PRIMARY   = 15'h0000;
  localparam logic [14:0] REG_SECONDARY = 15'h0001;
  localparam logic [14:0] REG_CHIP      = 15'h0003;
  localparam logic [14:0] REG_ID_LOW    = 15'h0004;
  localparam logic [14:0] REG_ID_HIGH   = 15'h0005;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FW_BIT        = 3;  // primary: four-wire select
  localparam int ASC_BIT       = 2;  // primary: address ascend
  localparam int LSB_BIT       = 1;  // primary: low bit leading
  localparam int SELF_RST_BIT  = 0;  // primary: self-clearing reset
  localparam int ONE_INSTR_BIT = 7;  // secondary: single instruction
  localparam int PAUSE_BIT     = 6;  // secondary: select line pause
  localparam int RSVD_MSB      = 5;  // secondary: reserved r/w field
  localparam int RSVD_LSB      = 3;
  localparam int SEC_RST_BIT   = 2;  // secondary: secondary reset
  localparam int PRI_RST_BIT   = 1;  // secondary: primary reset

  // index of each reset line in the pulse vector
  localparam int RST_SELF = 0;
  localparam int RST_PRI  = 1;
  localparam int RST_SEC  = 2;
  localparam int RST_N    = 3;

  // ---------------------------------------------------------------
  // identity defaults (values arbitrary, neutral)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CHIP_CATEGORY_DEFAULT = 8'h5A;
  localparam logic [15:0] PART_IDENT_DEFAULT    = 16'hC3A5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 25;
  localparam int RESET_PULSE_NS     = 100;
  localparam int RESET_PULSE_CYCLES =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W          = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h1,
    PH_INSTR = 3'h2,
    PH_DATA  = 3'h4
  } sp_phase_type;

  typedef struct packed {
    logic       four_wire_select;
    logic       address_ascend;
    logic       low_bit_leading;
    logic       one_instruction_only;
    logic       select_line_pause;
    logic [2:0] reserved_rw;
  } sp_cfg_type;

  localparam sp_cfg_type CFG_RESET = sp_cfg_type'(8'h00);

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio_in;
  } sp_pins_in_type;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
    logic sdo_out;
    logic sdo_oe;
  } sp_pins_out_type;

  typedef struct packed {
    logic                              sclk_s1;
    logic                              sclk_s2;
    logic                              sclk_prev;
    logic                              cs_s1;
    logic                              cs_s2;
    logic                              sdi_s1;
    logic                              sdi_s2;
    sp_phase_type                      phase;
    logic [3:0]                        bit_cnt;
    logic [15:0]                       shift;
    logic                              rw;
    logic [14:0]                       addr;
    logic [7:0]                        tx;
    logic                              done;
    sp_cfg_type                        cfg;
    logic [RST_N-1:0]                  req;
    logic [RST_N-1:0]                  pulse;
    logic [RST_N-1:0][RST_CNT_W-1:0]   cnt;
    sp_pins_out_type                   pins;
  } sp_state_type;

endpackage

// ===== design/sp_port_config.sv
// serial control port with its configuration and identity registers
`timescale 1ns/1ps
module sp_port_config
  import sp_pkg::*;
#(
  parameter logic [7:0]  CHIP_CATEGORY = sp_pkg::CHIP_CATEGORY_DEFAULT,
  parameter logic [15:0] PART_IDENT    = sp_pkg::PART_IDENT_DEFAULT
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // serial port pins
  input  wire sp_pkg::sp_pins_in_type  pins_in,
  output sp_pkg::sp_pins_out_type      pins_out,
  // configuration seen by the rest of the device
  output sp_pkg::sp_cfg_type           cfg,
  // reset lines: self-clearing, primary, secondary
  output logic [sp_pkg::RST_N-1:0]     reset_lines
);
  import sp_pkg::*;

  localparam logic [RST_CNT_W-1:0] PULSE_LAST =
    RST_CNT_W'(RESET_PULSE_CYCLES - 1);

  sp_state_type s;
  sp_state_type n;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  // used for the first byte and every streamed byte
  function automatic logic [7:0] rd_byte(input logic [14:0] a,
                                         input sp_state_type st);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_PRIMARY) begin
      v = {st.req[RST_SELF], st.cfg.low_bit_leading,
           st.cfg.address_ascend, st.cfg.four_wire_select,
           st.cfg.four_wire_select, st.cfg.address_ascend,
           st.cfg.low_bit_leading, st.req[RST_SELF]};
    end else if (a == REG_SECONDARY) begin
      v = {st.cfg.one_instruction_only, st.cfg.select_line_pause,
           st.cfg.reserved_rw, st.req[RST_SEC], st.req[RST_PRI],
           1'h0};
    end else if (a == REG_CHIP) begin
      v = CHIP_CATEGORY;
    end else if (a == REG_ID_LOW) begin
      v = PART_IDENT[7:0];
    end else if (a == REG_ID_HIGH) begin
      v = PART_IDENT[15:8];
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        rise;
    logic        fall;
    logic        sel;
    logic        lsb;
    logic        do_write;
    logic        obit;
    logic [7:0]  byte_in;
    logic [15:0] word_in;
    logic [2:0]  bidx;
    logic [RST_N-1:0] set_req;
    rise     = 1'h0;
    fall     = 1'h0;
    sel      = 1'h0;
    lsb      = 1'h0;
    do_write = 1'h0;
    obit     = 1'h0;
    byte_in  = 8'h00;
    word_in  = 16'h0000;
    bidx     = 3'h0;
    set_req  = '0;
    n = s;
    // two-flop synchronisers; only the second stage is looked at
    n.sclk_s1   = pins_in.sclk;
    n.sclk_s2   = s.sclk_s1;
    n.sclk_prev = s.sclk_s2;
    n.cs_s1     = pins_in.cs_n;
    n.cs_s2     = s.cs_s1;
    n.sdi_s1    = pins_in.sdio_in;
    n.sdi_s2    = s.sdi_s1;
    rise = s.sclk_s2 & ~s.sclk_prev;
    fall = ~s.sclk_s2 & s.sclk_prev;
    sel  = ~s.cs_s2;
    lsb  = s.cfg.low_bit_leading;

    if (!sel) begin
      // deselected: release the data lines at once
      n.pins.sdio_oe = 1'h0;
      n.pins.sdo_oe  = 1'h0;
      // with pausing on, a gap at a byte boundary keeps the stream
      if (!(s.cfg.select_line_pause && s.phase == PH_DATA &&
            s.bit_cnt == 4'h0)) begin
        n.phase = PH_IDLE;
      end
    end else begin
      case (s.phase)
        PH_IDLE: begin
          n.phase   = PH_INSTR;
          n.bit_cnt = 4'h0;
          n.done    = 1'h0;
        end
        PH_INSTR: begin
          if (rise) begin
            // lsb-first fills from the top so the word lands unreversed
            word_in = lsb ? {s.sdi_s2, s.shift[15:1]}
                          : {s.shift[14:0], s.sdi_s2};
            n.shift   = word_in;
            n.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == 4'hF) begin
              n.phase   = PH_DATA;
              n.bit_cnt = 4'h0;
              n.rw      = word_in[15];
              n.addr    = word_in[14:0];
              n.tx      = rd_byte(word_in[14:0], s);
            end
          end
        end
        PH_DATA: begin
          if (rise) begin
            byte_in = lsb ? {s.sdi_s2, s.shift[7:1]}
                          : {s.shift[6:0], s.sdi_s2};
            n.shift   = {8'h00, byte_in};
            n.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == 4'h7) begin
              n.bit_cnt = 4'h0;
              do_write  = ~s.rw & ~s.done;
              if (s.cfg.one_instruction_only) begin
                n.done = 1'h1;
              end else begin
                n.addr = s.cfg.address_ascend ? s.addr + 15'h0001
                                              : s.addr - 15'h0001;
                n.tx   = rd_byte(n.addr, s);
              end
            end
          end
          // read bits change on the falling edge, ahead of host sampling
          if (fall) begin
            bidx = lsb ? s.bit_cnt[2:0] : 3'h7 - s.bit_cnt[2:0];
            obit = s.tx[bidx];
            if (s.rw && !s.done) begin
              if (s.cfg.four_wire_select) begin
                n.pins.sdo_out = obit;
                n.pins.sdo_oe  = 1'h1;
                n.pins.sdio_oe = 1'h0;
              end else begin
                n.pins.sdio_out = obit;
                n.pins.sdio_oe  = 1'h1;
                n.pins.sdo_oe   = 1'h0;
              end
            end else begin
              n.pins.sdio_oe = 1'h0;
              n.pins.sdo_oe  = 1'h0;
            end
          end
        end
        default: begin
          n.phase = PH_IDLE;
        end
      endcase
    end

    // self-clearing reset bits: request, timed pulse, then clear
    for (int i = 0; i < RST_N; i++) begin
      if (s.pulse[i]) begin
        if (s.cnt[i] == '0) begin
          n.pulse[i] = 1'h0;
          n.req[i]   = 1'h0;
          if (i == RST_SELF) begin
            n.cfg = CFG_RESET;
          end
        end else begin
          n.cnt[i] = s.cnt[i] - {{(RST_CNT_W-1){1'h0}}, 1'h1};
        end
      end else if (s.req[i]) begin
        n.pulse[i] = 1'h1;
        n.cnt[i]   = PULSE_LAST;
      end
    end

    // register write at the end of a data byte; wins over the restore
    if (do_write) begin
      if (s.addr == REG_PRIMARY) begin
        // copy bits 7..4 are read-only and ignored
        n.cfg.four_wire_select = byte_in[FW_BIT];
        n.cfg.address_ascend   = byte_in[ASC_BIT];
        n.cfg.low_bit_leading  = byte_in[LSB_BIT];
        set_req[RST_SELF]      = byte_in[SELF_RST_BIT];
      end else if (s.addr == REG_SECONDARY) begin
        n.cfg.one_instruction_only = byte_in[ONE_INSTR_BIT];
        n.cfg.select_line_pause    = byte_in[PAUSE_BIT];
        n.cfg.reserved_rw          = byte_in[RSVD_MSB:RSVD_LSB];
        set_req[RST_SEC]           = byte_in[SEC_RST_BIT];
        set_req[RST_PRI]           = byte_in[PRI_RST_BIT];
      end
      // identity and unmapped offsets take no write
    end
    // a new request in the finishing cycle is kept, not lost
    n.req = n.req | set_req;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s       <= '0;
      s.phase <= PH_IDLE;
      s.cs_s1 <= 1'h1;
      s.cs_s2 <= 1'h1;
      s.cfg   <= CFG_RESET;
    end else begin
      s <= n;
    end
  end

  // outputs come straight from the state register
  assign pins_out    = s.pins;
  assign cfg         = s.cfg;
  assign reset_lines = s.pulse;

endmodule

// ===== test/sp_port_config_chk.sv
// checker: timing relations seen at the serial port block's ports
`timescale 1ns/1ps
module sp_chk
  import sp_pkg::*;
(
  // clock and reset
  input logic                    clk,
  input logic                    reset_n,
  // watched ports
  input sp_pkg::sp_pins_in_type  pins_in,
  input sp_pkg::sp_pins_out_type pins_out,
  input sp_pkg::sp_cfg_type      cfg,
  input logic [RST_N-1:0]        reset_lines
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // each reset line is exactly four cycles wide
  property p_self_pulse;
    $rose(reset_lines[0]) |-> reset_lines[0][*4] ##1 !reset_lines[0];
  endproperty
  a_self_pulse: assert property (p_self_pulse)
    else $error("self reset pulse width wrong");
  property p_pri_pulse;
    $rose(reset_lines[1]) |-> reset_lines[1][*4] ##1 !reset_lines[1];
  endproperty
  a_pri_pulse: assert property (p_pri_pulse)
    else $error("primary reset pulse width wrong");
  property p_sec_pulse;
    $rose(reset_lines[2]) |-> reset_lines[2][*4] ##1 !reset_lines[2];
  endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("secondary reset pulse width wrong");
  // the self-clearing reset puts the configuration back
  property p_restore;
    $fell(reset_lines[0]) |-> ##[0:4] (cfg == CFG_RESET);
  endproperty
  a_restore: assert property (p_restore)
    else $error("configuration not restored after self reset");
  // the other two lines leave the configuration alone
  property p_keep;
    $past(|reset_lines[2:1]) |-> $stable(cfg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("configuration moved during reset pulse");
  property p_sdo_mode;
    pins_out.sdo_oe |-> cfg.four_wire_select;
  endproperty
  a_sdo_mode: assert property (p_sdo_mode)
    else $error("separate output driven in three wire mode");
  property p_sdio_mode;
    pins_out.sdio_oe |-> !cfg.four_wire_select;
  endproperty
  a_sdio_mode: assert property (p_sdio_mode)
    else $error("data pin driven in four wire mode");
  // no driver left on after the frame has ended
  property p_idle;
    pins_in.cs_n[*6] |-> !(pins_out.sdio_oe || pins_out.sdo_oe);
  endproperty
  a_idle: assert property (p_idle)
    else $error("output driven outside a frame");
endmodule
bind sp_port_config sp_chk sp_chk_i (.clk(clk), .reset_n(reset_n),
  .pins_in(pins_in), .pins_out(pins_out), .cfg(cfg),
  .reset_lines(reset_lines));

// ===== test/sp_host_model.sv
// host model: serial port master, mode 0, clock idles low
`timescale 1ns/1ps
module sp_host
  import sp_pkg::*;
(
  // clock and line levels
  input  logic                    clk,
  input  logic                    sdio_wire,
  input  sp_pkg::sp_pins_out_type pins_out,
  // host drives
  output logic                    sclk = 1'b0,
  output logic                    cs_n = 1'b1,
  output logic                    sdo_host = 1'b0
);
  // ------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------
  logic lsb = 1'b0; // host follows the device's bit order
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // instruction then n bytes; read bits taken late in the high phase
  task automatic xfer(input logic rw, input logic [14:0] a, input int n,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [15:0] ins;
    int i;
    int k;
    ins = {rw, a};
    rd = 16'h0000;
    cs_n = 1'b0;
    half();
    for (i = 0; i < 16 + 8 * n; i++) begin
      k = 8 * ((i - 16) / 8) + (lsb ? i % 8 : 7 - i % 8);
      if (i < 16) begin
        sdo_host = ins[lsb ? i : 15 - i];
      end else begin
        // released line toggles so a stale value never passes
        sdo_host = rw ? ~sdo_host : wd[k];
      end
      half();
      sclk = 1'b1;
      half();
      if (i >= 16)
        rd[k] = pins_out.sdo_oe ? pins_out.sdo_out : sdio_wire;
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdo_host = ~sdo_host;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ===== test/test_sp_port_config.sv
// testbench: register access through the serial control port
`timescale 1ns/1ps
module test_sp_port_config;
  import sp_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             sclk;
  logic             cs_n;
  logic             sdo_host;
  sp_pins_in_type   pins_in;
  sp_pins_out_type  pins_out;
  sp_cfg_type       cfg;
  logic [RST_N-1:0] reset_lines;
  logic [RST_N-1:0] seen = '0;
  logic [15:0]      rd;
  int               mismatches = 0;
  int               cmp_count = 0;
  // streamed pairs: the second byte of a frame lands in the upper half
  localparam logic [15:0] ID_DOWN = {CHIP_CATEGORY_DEFAULT,
                                     PART_IDENT_DEFAULT[7:0]};
  localparam logic [15:0] ID_SWAP = {PART_IDENT_DEFAULT[7:0],
                                     PART_IDENT_DEFAULT[15:8]};
  wire sdio_wire = pins_out.sdio_oe ? pins_out.sdio_out : sdo_host;
  assign pins_in = {sclk, cs_n, sdio_wire};
  always #12.5 clk = ~clk;
  // pulses end before a frame does, so keep a sticky record
  always @(posedge clk) seen <= seen | reset_lines;
  sp_port_config sp_port_config_i (.clk(clk), .reset_n(reset_n),
    .pins_in(pins_in), .pins_out(pins_out), .cfg(cfg),
    .reset_lines(reset_lines));
  sp_host sp_host_i (.clk(clk), .sdio_wire(sdio_wire),
    .pins_out(pins_out), .sclk(sclk), .cs_n(cs_n), .sdo_host(sdo_host));
  // ------------------------------------------------------------
  // access and report tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d,
      input int n = 1);
    sp_host_i.xfer(1'b0, a, n, d, rd);
  endtask
  task automatic rc(input logic [14:0] a, input logic [15:0] e,
      input int n = 1);
    sp_host_i.xfer(1'b1, a, n, 16'h0000, rd);
    chk($sformatf("register %h", a), e, n == 2 ? rd : {8'h00, rd[7:0]});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    rc(REG_PRIMARY, 16'h0000);
    rc(REG_SECONDARY, 16'h0000);
    rc(REG_ID_LOW, ID_DOWN, 2);
    wr(REG_CHIP, 16'h00FF);
    wr(REG_PRIMARY, 16'h000C);
    chk("four wire select", 16'h0001, cfg.four_wire_select);
    rc(REG_PRIMARY, 16'h003C);
    rc(REG_ID_LOW, PART_IDENT_DEFAULT, 2);
    rc(REG_CHIP, {8'h00, CHIP_CATEGORY_DEFAULT});
    wr(REG_PRIMARY, 16'h0002);
    sp_host_i.lsb = 1'b1;
    rc(REG_PRIMARY, 16'h0042);
    rc(REG_ID_HIGH, ID_SWAP, 2);
    wr(REG_PRIMARY, 16'h0004);
    sp_host_i.lsb = 1'b0;
    wr(REG_SECONDARY, 16'h0080);
    wr(REG_PRIMARY, 16'h0004, 2);
    rc(REG_SECONDARY, 16'h0080);
    wr(REG_SECONDARY, 16'h0039);
    rc(REG_SECONDARY, 16'h0038);
    // secondary and primary first, while the configuration is not zero
    // the record is sticky, so each step adds exactly one line to it;
    // the self reset also sets mode bits that the restore must undo
    for (int i = 2; i >= 0; i--) begin
      wr(i == 0 ? REG_PRIMARY : REG_SECONDARY,
         i == 0 ? 16'h000D : 16'(1 << i));
      chk("reset lines", 16'(8 - (1 << i)), 16'(seen));
    end
    rc(REG_PRIMARY, 16'h0000);
    rc(REG_SECONDARY, 16'h0000);
    // pausing on: a frame cut at a byte boundary resumes at address 0,
    // so the next frame's first byte lands in the primary register
    wr(REG_SECONDARY, 16'h0040);
    wr(15'h0800, 16'h0000);
    chk("stalled stream resumed", 16'h0001, cfg.four_wire_select);
    complete_run();
  end
endmodule
